// >>> hdl/abs_time_pkg.sv
package abs_time_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned US_PER_SECOND = 1_000_000;
  localparam int unsigned US_CYCLES_INT = CLK_HZ / US_PER_SECOND;
  localparam logic [5:0]  US_CYCLES     = US_CYCLES_INT[5:0];
  localparam logic [19:0] US_LAST       = 20'(US_PER_SECOND - 1);
  localparam logic [19:0] US_HALF       = 20'(US_PER_SECOND / 2);

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_GPS_PORT  = 8'h04;
  localparam logic [7:0] ADDR_LOCK_LIM  = 8'h08;
  localparam logic [7:0] ADDR_INTERVALS = 8'h0C;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;
  localparam logic [7:0] ADDR_SECONDS   = 8'h14;
  localparam logic [7:0] ADDR_MICROS    = 8'h18;

  // CTRL fields
  localparam int CTRL_SOURCE    = 0;
  localparam int CTRL_GPS_MODE  = 1;
  localparam int CTRL_DEMAND    = 2;
  localparam int CTRL_PROF_LO   = 3;
  localparam int CTRL_TRANSPORT = 5;
  localparam int CTRL_DOM_LO    = 8;
  // INTERVALS fields
  localparam int IVL_ANN_LO     = 0;
  localparam int IVL_SYNC_LO    = 8;
  localparam int IVL_DREQ_LO    = 16;

  typedef enum logic [1:0] {PROFILE_1588V2, PROFILE_8021AS, PROFILE_8021AS_AUTO} profile_e;

  localparam logic [15:0]       GPS_PORT_RST   = 16'h277E;
  localparam logic [6:0]        LOCK_LIM_RST   = 7'h01;
  localparam logic [6:0]        LOCK_LIM_MIN   = 7'h01;
  localparam logic [6:0]        LOCK_LIM_MAX   = 7'h64;
  localparam logic [6:0]        DOMAIN_RST     = 7'h00;
  localparam logic signed [3:0] ANN_RST        = 4'sh1;
  localparam logic signed [3:0] SYNC_RST       = 4'sh1;
  localparam logic signed [3:0] DREQ_RST       = 4'sh0;
  localparam logic signed [3:0] ANN_MIN        = -4'sd2;
  localparam logic signed [3:0] IVL_MIN        = -4'sd7;
  localparam logic signed [3:0] IVL_MAX        = 4'sd3;
  localparam logic              SOURCE_GPS     = 1'b0;
  localparam logic              TRANSPORT_UDP  = 1'b0;

endpackage

// >>> hdl/absolute_time_sync_logic.sv
// Function
// - Time source is GPS or PTP; GPS after reset.
// - GPS mode accepts only sentences of the selected type, RMC default or GGA.
// - NMEA and pulse locked: seconds from sentence, microseconds from pulse.
// - NMEA locked, pulse unlocked: seconds from sentence only if pulse not demanded.
// - Only pulse locked: microseconds from pulse; neither locked: nothing updated.
// - Pulse-lock demand for date updates, on after reset.
// - GPS mode emits GPS packets to a configurable port, default 10110.
// - PTP mode emits no GPS packets.
// - PTP profile 1588v2, 802.1AS or automotive; UDP only with 1588v2.
// - Layer-2 transport allowed with every profile; UDP after reset.
// - PTP locked only while absolute offset within limit 1 to 100 us, default 1.
// - PTP domain number 0 to 127, default 0.
// - Announce log interval -2 to 3, default 1.
// - Sync log interval -7 to 3, default 1.
// - Delay request log interval -7 to 3, default 0.
// - Full second from pulse, PTP master, or internal 1 Hz tick.
//
// Local design decisions: register access over AHB-Lite and the register offsets.
module absolute_time_sync_logic (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        nmeaLocked,
  input  wire logic        ppsLocked,
  input  wire logic        nmeaValid,
  input  wire logic        nmeaIsGga,
  input  wire logic [31:0] nmeaSeconds,
  input  wire logic        ppsPin,
  input  wire logic        ptpTracking,
  input  wire logic        ptpSecond,
  input  wire logic [31:0] ptpSeconds,
  input  wire logic [31:0] ptpOffsetUs,
  output logic             sourceIsPtp,
  output logic             gpsModeGga,
  output logic             gpsPacketSend,
  output logic [15:0]      gpsDestPort,
  output logic [1:0]       ptpProfile,
  output logic             ptpTransportL2,
  output logic [6:0]       ptpDomain,
  output logic [3:0]       ptpLogAnnounce,
  output logic [3:0]       ptpLogSync,
  output logic [3:0]       ptpLogDelayReq,
  output logic             ptpLocked,
  output logic [31:0]      sysSeconds,
  output logic [19:0]      sysMicros,
  output logic             fullSecond
);

  typedef struct packed {
    logic                         source;
    logic                         gpsMode;
    logic                         demandPulseLockForDate;
    abs_time_pkg::profile_e       profile;
    logic                         transport;
    logic [6:0]                   domain;
    logic [15:0]                  gpsPort;
    logic [6:0]                   lockLimit;
    logic signed [3:0]            logAnnounce;
    logic signed [3:0]            logSync;
    logic signed [3:0]            logDelayReq;
    logic                         ppsMeta;
    logic                         ppsSync;
    logic                         ppsPrev;
    logic [5:0]                   usDiv;
    logic [19:0]                  micros;
    logic [31:0]                  seconds;
    logic                         ptpLocked;
    logic                         fullSecond;
    logic                         gpsPacket;
    logic                         wrPend;
    logic [7:0]                   wrAddr;
    logic [31:0]                  rdata;
  } state_s;

  state_s state_q;
  state_s state_d;

  function automatic logic ivlFits(input logic signed [3:0] v, input logic signed [3:0] lo);
    ivlFits = (v >= lo) && (v <= abs_time_pkg::IVL_MAX);
  endfunction

  function automatic logic [31:0] absVal(input logic [31:0] v);
    absVal = v[31] ? 32'(-v) : v;
  endfunction

  logic        addrPhase;
  logic        ppsEdge;
  logic        sentenceOk;
  logic        gpsLocked;
  logic        usTick;
  logic        secWrap;
  logic        ctrlLegal;
  logic [31:0] offsetAbs;
  logic [31:0] readMux;

  assign addrPhase  = hsel && htrans[1] && hready;
  assign ppsEdge    = state_q.ppsSync && !state_q.ppsPrev;
  assign sentenceOk = nmeaValid && (nmeaIsGga == state_q.gpsMode);
  assign gpsLocked  = nmeaLocked && ppsLocked;
  assign usTick     = (state_q.usDiv == abs_time_pkg::US_CYCLES - 6'h01);
  assign secWrap    = usTick && (state_q.micros == abs_time_pkg::US_LAST);
  assign offsetAbs  = absVal(ptpOffsetUs);
  // UDP is only legal together with 1588v2; illegal profile code is refused
  assign ctrlLegal  = (hwdata[abs_time_pkg::CTRL_PROF_LO +: 2] != 2'h3) &&
                      ((hwdata[abs_time_pkg::CTRL_TRANSPORT] != abs_time_pkg::TRANSPORT_UDP) ||
                       (hwdata[abs_time_pkg::CTRL_PROF_LO +: 2] == 2'(abs_time_pkg::PROFILE_1588V2)));

  always_comb begin
    readMux = 32'h0000_0000;
    unique case (haddr[7:0])
      abs_time_pkg::ADDR_CTRL: begin
        readMux[abs_time_pkg::CTRL_SOURCE]          = state_q.source;
        readMux[abs_time_pkg::CTRL_GPS_MODE]        = state_q.gpsMode;
        readMux[abs_time_pkg::CTRL_DEMAND]          = state_q.demandPulseLockForDate;
        readMux[abs_time_pkg::CTRL_PROF_LO +: 2]    = state_q.profile;
        readMux[abs_time_pkg::CTRL_TRANSPORT]       = state_q.transport;
        readMux[abs_time_pkg::CTRL_DOM_LO +: 7]     = state_q.domain;
      end
      abs_time_pkg::ADDR_GPS_PORT:  readMux[15:0] = state_q.gpsPort;
      abs_time_pkg::ADDR_LOCK_LIM:  readMux[6:0]  = state_q.lockLimit;
      abs_time_pkg::ADDR_INTERVALS: begin
        readMux[abs_time_pkg::IVL_ANN_LO +: 4]  = state_q.logAnnounce;
        readMux[abs_time_pkg::IVL_SYNC_LO +: 4] = state_q.logSync;
        readMux[abs_time_pkg::IVL_DREQ_LO +: 4] = state_q.logDelayReq;
      end
      abs_time_pkg::ADDR_STATUS:    readMux[3:0]  = {ptpTracking, state_q.ptpLocked, ppsLocked, nmeaLocked};
      abs_time_pkg::ADDR_SECONDS:   readMux       = state_q.seconds;
      abs_time_pkg::ADDR_MICROS:    readMux[19:0] = state_q.micros;
      default:                      readMux       = 32'h0000_0000;
    endcase
  end

  always_comb begin
    state_d            = state_q;
    state_d.ppsMeta    = ppsPin;
    state_d.ppsSync    = state_q.ppsMeta;
    state_d.ppsPrev    = state_q.ppsSync;
    state_d.fullSecond = 1'b0;
    state_d.gpsPacket  = 1'b0;

    // Bus: read data captured in the address phase, write applied in the data phase
    state_d.wrPend = addrPhase && hwrite;
    if (addrPhase) begin
      state_d.wrAddr = haddr[7:0];
      state_d.rdata  = hwrite ? 32'h0000_0000 : readMux;
    end
    if (state_q.wrPend) begin
      unique case (state_q.wrAddr)
        abs_time_pkg::ADDR_CTRL: begin
          state_d.source                 = hwdata[abs_time_pkg::CTRL_SOURCE];
          state_d.gpsMode                = hwdata[abs_time_pkg::CTRL_GPS_MODE];
          state_d.demandPulseLockForDate = hwdata[abs_time_pkg::CTRL_DEMAND];
          state_d.domain                 = hwdata[abs_time_pkg::CTRL_DOM_LO +: 7];
          if (ctrlLegal) begin
            state_d.profile   = abs_time_pkg::profile_e'(hwdata[abs_time_pkg::CTRL_PROF_LO +: 2]);
            state_d.transport = hwdata[abs_time_pkg::CTRL_TRANSPORT];
          end
        end
        abs_time_pkg::ADDR_GPS_PORT: state_d.gpsPort = hwdata[15:0];
        abs_time_pkg::ADDR_LOCK_LIM: begin
          if (hwdata[31:0] >= 32'(abs_time_pkg::LOCK_LIM_MIN) &&
              hwdata[31:0] <= 32'(abs_time_pkg::LOCK_LIM_MAX)) begin
            state_d.lockLimit = hwdata[6:0];
          end
        end
        abs_time_pkg::ADDR_INTERVALS: begin
          if (ivlFits(hwdata[abs_time_pkg::IVL_ANN_LO +: 4], abs_time_pkg::ANN_MIN)) begin
            state_d.logAnnounce = hwdata[abs_time_pkg::IVL_ANN_LO +: 4];
          end
          if (ivlFits(hwdata[abs_time_pkg::IVL_SYNC_LO +: 4], abs_time_pkg::IVL_MIN)) begin
            state_d.logSync = hwdata[abs_time_pkg::IVL_SYNC_LO +: 4];
          end
          if (ivlFits(hwdata[abs_time_pkg::IVL_DREQ_LO +: 4], abs_time_pkg::IVL_MIN)) begin
            state_d.logDelayReq = hwdata[abs_time_pkg::IVL_DREQ_LO +: 4];
          end
        end
        default: ;
      endcase
    end

    // Local microsecond counter keeps time when no source updates it
    state_d.usDiv = usTick ? 6'h00 : state_q.usDiv + 6'h01;
    if (usTick) begin
      state_d.micros = secWrap ? 20'h0_0000 : state_q.micros + 20'h0_0001;
      if (secWrap) begin
        state_d.seconds = state_q.seconds + 32'h0000_0001;
      end
    end

    if (state_q.source == abs_time_pkg::SOURCE_GPS) begin
      // Pulse realigns microseconds; seconds step only if the local count has not wrapped yet
      if (ppsEdge && ppsLocked) begin
        state_d.micros = 20'h0_0000;
        state_d.usDiv  = 6'h00;
        if (state_q.micros >= abs_time_pkg::US_HALF) begin
          state_d.seconds = state_q.seconds + 32'h0000_0001;
        end
      end
      // Sentence loads seconds; pulse lock demanded unless the setting is off
      if (sentenceOk && nmeaLocked && (ppsLocked || !state_q.demandPulseLockForDate)) begin
        state_d.seconds = nmeaSeconds;
      end
      state_d.gpsPacket  = sentenceOk;
      state_d.fullSecond = gpsLocked ? ppsEdge : secWrap;
    end else begin
      if (ptpSecond && ptpTracking) begin
        state_d.seconds = ptpSeconds;
        state_d.micros  = 20'h0_0000;
        state_d.usDiv   = 6'h00;
      end
      state_d.fullSecond = ptpTracking ? ptpSecond : secWrap;
    end

    state_d.ptpLocked = (state_q.source != abs_time_pkg::SOURCE_GPS) && ptpTracking &&
                        (offsetAbs <= 32'(state_q.lockLimit));
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q                        <= '0;
      state_q.source                 <= abs_time_pkg::SOURCE_GPS;
      state_q.demandPulseLockForDate <= 1'b1;
      state_q.profile                <= abs_time_pkg::PROFILE_1588V2;
      state_q.transport              <= abs_time_pkg::TRANSPORT_UDP;
      state_q.domain                 <= abs_time_pkg::DOMAIN_RST;
      state_q.gpsPort                <= abs_time_pkg::GPS_PORT_RST;
      state_q.lockLimit              <= abs_time_pkg::LOCK_LIM_RST;
      state_q.logAnnounce            <= abs_time_pkg::ANN_RST;
      state_q.logSync                <= abs_time_pkg::SYNC_RST;
      state_q.logDelayReq            <= abs_time_pkg::DREQ_RST;
    end else begin
      state_q <= state_d;
    end
  end

  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = state_q.rdata;
  assign sourceIsPtp    = state_q.source;
  assign gpsModeGga     = state_q.gpsMode;
  assign gpsPacketSend  = state_q.gpsPacket;
  assign gpsDestPort    = state_q.gpsPort;
  assign ptpProfile     = state_q.profile;
  assign ptpTransportL2 = state_q.transport;
  assign ptpDomain      = state_q.domain;
  assign ptpLogAnnounce = state_q.logAnnounce;
  assign ptpLogSync     = state_q.logSync;
  assign ptpLogDelayReq = state_q.logDelayReq;
  assign ptpLocked      = state_q.ptpLocked;
  assign sysSeconds     = state_q.seconds;
  assign sysMicros      = state_q.micros;
  assign fullSecond     = state_q.fullSecond;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_reset_gps_source: assert property ($fell(rst) |-> !sourceIsPtp && !ptpLocked)
    else $error("source not GPS after reset");
  a_packet_type_match: assert property (gpsPacketSend |-> $past(nmeaValid && (nmeaIsGga == gpsModeGga)))
    else $error("packet without matching sentence");
  a_date_load: assert property (!sourceIsPtp && nmeaValid && nmeaIsGga == gpsModeGga && gpsLocked
                                |=> sysSeconds == $past(nmeaSeconds))
    else $error("seconds not loaded from sentence");
  a_date_hold: assert property (!sourceIsPtp && state_q.demandPulseLockForDate && !ppsLocked && !secWrap
                                ##0 $past(!sourceIsPtp) |=> $stable(sysSeconds))
    else $error("seconds changed without pulse lock");
  a_pulse_micros: assert property (!sourceIsPtp && ppsEdge && ppsLocked |=> sysMicros == 20'h0_0000)
    else $error("pulse did not clear microseconds");
  a_no_packet_ptp: assert property (sourceIsPtp && $past(sourceIsPtp) |-> !gpsPacketSend)
    else $error("GPS packet in PTP mode");
  a_udp_profile: assert property (ptpTransportL2 == abs_time_pkg::TRANSPORT_UDP
                                  |-> ptpProfile == abs_time_pkg::PROFILE_1588V2)
    else $error("UDP with non-1588v2 profile");
  a_lock_offset: assert property (ptpLocked |-> $past(ptpTracking && offsetAbs <= 32'(state_q.lockLimit)))
    else $error("PTP locked outside offset limit");
  a_limit_range: assert property (state_q.lockLimit >= abs_time_pkg::LOCK_LIM_MIN &&
                                  state_q.lockLimit <= abs_time_pkg::LOCK_LIM_MAX)
    else $error("lock limit out of range");
  a_ivl_range: assert property (ivlFits(state_q.logAnnounce, abs_time_pkg::ANN_MIN) &&
                                ivlFits(state_q.logSync, abs_time_pkg::IVL_MIN) &&
                                ivlFits(state_q.logDelayReq, abs_time_pkg::IVL_MIN))
    else $error("interval out of range");
  a_micros_bound: assert property (sysMicros <= abs_time_pkg::US_LAST)
    else $error("microseconds past one second");
  a_internal_tick: assert property (!sourceIsPtp && !gpsLocked && secWrap |=> fullSecond)
    else $error("internal tick lost");
  a_port_reset: assert property ($fell(rst)
    |-> gpsDestPort == abs_time_pkg::GPS_PORT_RST && ptpDomain == abs_time_pkg::DOMAIN_RST)
    else $error("port or domain not at reset value");
  a_setup_reset: assert property ($fell(rst)
    |-> state_q.demandPulseLockForDate && ptpTransportL2 == abs_time_pkg::TRANSPORT_UDP)
    else $error("setup not at reset value");
  a_ivl_reset: assert property ($fell(rst)
    |-> ptpLogAnnounce == abs_time_pkg::ANN_RST && ptpLogSync == abs_time_pkg::SYNC_RST
    && ptpLogDelayReq == abs_time_pkg::DREQ_RST)
    else $error("intervals not at reset value");
  a_packet_send: assert property (!sourceIsPtp && nmeaValid && nmeaIsGga == gpsModeGga
    |=> gpsPacketSend)
    else $error("matching sentence sent no packet");
  a_date_relaxed: assert property (!sourceIsPtp && sentenceOk && nmeaLocked
    && !state_q.demandPulseLockForDate |=> sysSeconds == $past(nmeaSeconds))
    else $error("seconds not loaded with demand off");
  a_pulse_second: assert property (!sourceIsPtp && gpsLocked && ppsEdge
    |=> fullSecond)
    else $error("pulse did not mark full second");
  a_ptp_second: assert property (sourceIsPtp && ptpTracking && ptpSecond
    |=> sysSeconds == $past(ptpSeconds) && sysMicros == 20'h0_0000 && fullSecond)
    else $error("master second not applied");
  a_gps_unlocked: assert property (!sourceIsPtp
    |=> !ptpLocked)
    else $error("PTP locked in GPS mode");
  a_domain_write: assert property (state_q.wrPend && state_q.wrAddr == abs_time_pkg::ADDR_CTRL
    |=> ptpDomain == $past(hwdata[abs_time_pkg::CTRL_DOM_LO +: 7]))
    else $error("domain not written");
  a_profile_keep: assert property (!ctrlLegal && state_q.wrPend
    && state_q.wrAddr == abs_time_pkg::ADDR_CTRL |=> $stable(ptpProfile) && $stable(ptpTransportL2))
    else $error("illegal profile or transport taken");
  a_limit_keep: assert property (state_q.wrPend && state_q.wrAddr == abs_time_pkg::ADDR_LOCK_LIM
    && hwdata > 32'(abs_time_pkg::LOCK_LIM_MAX) |=> $stable(state_q.lockLimit))
    else $error("limit above range taken");
  a_sync_keep: assert property (state_q.wrPend && state_q.wrAddr == abs_time_pkg::ADDR_INTERVALS
    && !ivlFits(hwdata[abs_time_pkg::IVL_SYNC_LO +: 4], abs_time_pkg::IVL_MIN) |=> $stable(ptpLogSync))
    else $error("sync interval out of range taken");
  a_dreq_keep: assert property (state_q.wrPend && state_q.wrAddr == abs_time_pkg::ADDR_INTERVALS
    && !ivlFits(hwdata[abs_time_pkg::IVL_DREQ_LO +: 4], abs_time_pkg::IVL_MIN) |=> $stable(ptpLogDelayReq))
    else $error("delay request interval out of range taken");
  a_micros_step: assert property (usTick && !secWrap && !ppsEdge && !ptpSecond
    |=> sysMicros == $past(sysMicros) + 20'h0_0001)
    else $error("microseconds did not advance");

  c_date_load:  cover property (!sourceIsPtp && sentenceOk && gpsLocked);
  c_pulse_only: cover property (!sourceIsPtp && ppsEdge && ppsLocked && !nmeaLocked);
  c_ptp_lock:   cover property ($rose(ptpLocked));
  c_packet:     cover property (gpsPacketSend);
  c_relaxed_load: cover property (sentenceOk && nmeaLocked && !ppsLocked && !state_q.demandPulseLockForDate);

endmodule

// >>> verification/time_source_model.sv
module time_source_model (
  input  wire logic        clk_sys,
  output logic             nmeaLocked,
  output logic             ppsLocked,
  output logic             nmeaValid,
  output logic             nmeaIsGga,
  output logic [31:0]      nmeaSeconds,
  output logic             ppsPin,
  output logic             ptpTracking,
  output logic             ptpSecond,
  output logic [31:0]      ptpSeconds,
  output logic [31:0]      ptpOffsetUs
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {nmeaLocked, ppsLocked, nmeaValid, nmeaIsGga, ppsPin, ptpTracking, ptpSecond} = 7'h00;
    nmeaSeconds = 32'hA5A5A5A5;
    ptpSeconds = 32'h5A5A5A5A;
    ptpOffsetUs = 32'h00000000;
  end

  task automatic setLocks(input logic n, input logic p, input logic t, input logic [31:0] off);
    nmeaLocked <= n;
    ppsLocked <= p;
    ptpTracking <= t;
    ptpOffsetUs <= off;
  endtask

  // Lines are inverted once released so a stale value cannot pass for a fresh one
  task automatic sendSentence(input logic gga, input logic [31:0] s);
    @(posedge clk_sys);
    nmeaValid <= 1'b1;
    nmeaIsGga <= gga;
    nmeaSeconds <= s;
    @(posedge clk_sys);
    nmeaValid <= 1'b0;
    nmeaIsGga <= ~gga;
    nmeaSeconds <= ~s;
  endtask

  task automatic pulse;
    @(posedge clk_sys);
    ppsPin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ppsPin <= 1'b0;
  endtask

  task automatic ptpTick(input logic [31:0] s);
    @(posedge clk_sys);
    ptpSecond <= 1'b1;
    ptpSeconds <= s;
    @(posedge clk_sys);
    ptpSecond <= 1'b0;
    ptpSeconds <= ~s;
  endtask
endmodule

// >>> verification/absolute_time_sync_logic_test.sv
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

module absolute_time_sync_logic_test;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {string n; logic [31:0] v;} note_s;
  note_s       notes[$];
  note_s       cur;
  logic        clk_sys = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rdPhase = 1'b0;
  logic [1:0]  htrans = 2'b00, ptpProfile;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, nmeaSeconds, ptpSeconds, ptpOffsetUs, sysSeconds;
  logic [31:0] pktCount = '0, secCount = '0, base;
  logic        hready, hresp, nmeaLocked, ppsLocked, nmeaValid, nmeaIsGga, ppsPin, ptpTracking, ptpSecond;
  logic        sourceIsPtp, gpsModeGga, gpsPacketSend, ptpTransportL2, ptpLocked, fullSecond;
  logic [15:0] gpsDestPort, port;
  logic [6:0]  ptpDomain, dom;
  logic [3:0]  ptpLogAnnounce, ptpLogSync, ptpLogDelayReq;
  logic [19:0] sysMicros, us0;
  int          err_total = 0, check_count = 0, seed = 71;

  always #12.5 clk_sys = ~clk_sys;

  time_source_model src (.clk_sys(clk_sys), .nmeaLocked(nmeaLocked), .ppsLocked(ppsLocked),
    .nmeaValid(nmeaValid), .nmeaIsGga(nmeaIsGga), .nmeaSeconds(nmeaSeconds), .ppsPin(ppsPin),
    .ptpTracking(ptpTracking), .ptpSecond(ptpSecond), .ptpSeconds(ptpSeconds), .ptpOffsetUs(ptpOffsetUs));

  absolute_time_sync_logic uut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .nmeaLocked(nmeaLocked), .ppsLocked(ppsLocked), .nmeaValid(nmeaValid),
    .nmeaIsGga(nmeaIsGga), .nmeaSeconds(nmeaSeconds), .ppsPin(ppsPin), .ptpTracking(ptpTracking),
    .ptpSecond(ptpSecond), .ptpSeconds(ptpSeconds), .ptpOffsetUs(ptpOffsetUs), .sourceIsPtp(sourceIsPtp),
    .gpsModeGga(gpsModeGga), .gpsPacketSend(gpsPacketSend), .gpsDestPort(gpsDestPort),
    .ptpProfile(ptpProfile), .ptpTransportL2(ptpTransportL2), .ptpDomain(ptpDomain),
    .ptpLogAnnounce(ptpLogAnnounce), .ptpLogSync(ptpLogSync), .ptpLogDelayReq(ptpLogDelayReq),
    .ptpLocked(ptpLocked), .sysSeconds(sysSeconds), .sysMicros(sysMicros), .fullSecond(fullSecond));

  task automatic test_done;
    `CHK("notes left", 0, notes.size())
    $display("Comparisons %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Always leaves one idle cycle, so a read never follows its own write back to back
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (hready !== 1'b1 && n < 64);
      if (n >= 64) begin
        err_total++;
        test_done();
      end
      hsel <= 1'b0;
      htrans <= 2'b00;
      if (k == 0) hwdata <= d;
    end
    @(posedge clk_sys);
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    notes.push_back('{n, e});
    bus(a, 1'b0, 32'h00000000);
  endtask

  always @(posedge clk_sys) begin
    if (!rst) begin
      pktCount <= pktCount + 32'(gpsPacketSend);
      secCount <= secCount + 32'(fullSecond);
    end
    if (rdPhase && hready && notes.size() > 0) begin
      cur = notes.pop_front();
      `CHK(cur.n, cur.v, hrdata)
      `CHK("hresp", 1'b0, hresp)
    end
    rdPhase <= hsel && htrans[1] && hready && !hwrite;
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rd("ctrl", 8'h00, 32'h00000004);
    rd("port", 8'h04, 32'h0000277E);
    rd("limit", 8'h08, 32'h00000001);
    rd("intervals", 8'h0C, 32'h00000101);
    rd("unmapped", 8'h1C, 32'h00000000);
    `CHK("source", 1'b0, sourceIsPtp)
    $display("reset values done");
    dom = 7'($random(seed));
    port = 16'($random(seed));
    bus(8'h04, 1'b1, {16'h0000, port});
    `CHK("dest port", port, gpsDestPort)
    bus(8'h08, 1'b1, 32'h00000000);
    bus(8'h08, 1'b1, 32'h00000065);
    rd("limit", 8'h08, 32'h00000001);
    bus(8'h08, 1'b1, 32'h00000064);
    rd("limit", 8'h08, 32'h00000064);
    bus(8'h0C, 1'b1, 32'h0009040D);
    rd("intervals", 8'h0C, 32'h00090101);
    bus(8'h0C, 1'b1, 32'h00080E02);
    rd("intervals", 8'h0C, 32'h00090E02);
    `CHK("announce out", 4'h2, ptpLogAnnounce)
    `CHK("sync out", 4'hE, ptpLogSync)
    `CHK("delay req out", 4'h9, ptpLogDelayReq)
    for (int p = 0; p < 3; p++) begin
      bus(8'h00, 1'b1, {17'h0, dom, 2'b00, 1'b1, 2'(p), 3'b100});
      `CHK("profile", 2'(p), ptpProfile)
      `CHK("layer2", 1'b1, ptpTransportL2)
    end
    bus(8'h00, 1'b1, {17'h0, dom, 2'b00, 1'b0, 2'b01, 3'b100});
    `CHK("profile kept", 2'b10, ptpProfile)
    `CHK("domain", dom, ptpDomain)
    bus(8'h00, 1'b1, {17'h0, dom, 2'b00, 1'b0, 2'b00, 3'b100});
    `CHK("udp", 1'b0, ptpTransportL2)
    $display("configuration done");
    src.setLocks(1'b1, 1'b1, 1'b0, 32'h0);
    src.sendSentence(1'b0, 32'd1000);
    repeat (4) @(posedge clk_sys);
    `CHK("seconds", 32'd1000, sysSeconds)
    `CHK("packets", 32'd1, pktCount)
    src.sendSentence(1'b1, 32'd1500);
    repeat (4) @(posedge clk_sys);
    `CHK("packets", 32'd1, pktCount)
    bus(8'h00, 1'b1, {17'h0, dom, 8'b00000110});
    `CHK("gga mode", 1'b1, gpsModeGga)
    src.sendSentence(1'b1, 32'd1600);
    repeat (4) @(posedge clk_sys);
    `CHK("seconds", 32'd1600, sysSeconds)
    src.pulse();
    repeat (2) @(posedge clk_sys);
    `CHK("micros reset", 1'b1, sysMicros < 20'd2)
    `CHK("full seconds", 32'd1, secCount)
    $display("gps both locked done");
    src.setLocks(1'b1, 1'b0, 1'b0, 32'h0);
    src.sendSentence(1'b1, 32'd2000);
    repeat (4) @(posedge clk_sys);
    `CHK("seconds held", 32'd1600, sysSeconds)
    bus(8'h00, 1'b1, {17'h0, dom, 8'b00000010});
    src.sendSentence(1'b1, 32'd2000);
    repeat (4) @(posedge clk_sys);
    `CHK("seconds", 32'd2000, sysSeconds)
    src.setLocks(1'b0, 1'b1, 1'b0, 32'h0);
    src.sendSentence(1'b1, 32'd3000);
    repeat (200) @(posedge clk_sys);
    `CHK("seconds held", 32'd2000, sysSeconds)
    src.pulse();
    repeat (2) @(posedge clk_sys);
    `CHK("micros reset", 1'b1, sysMicros < 20'd2)
    src.setLocks(1'b0, 1'b0, 1'b0, 32'h0);
    repeat (200) @(posedge clk_sys);
    src.pulse();
    repeat (2) @(posedge clk_sys);
    `CHK("micros kept", 1'b1, sysMicros > 20'd3)
    us0 = sysMicros;
    repeat (400) @(posedge clk_sys);
    `CHK("micros run", us0 + 20'd10, sysMicros)
    $display("gps partial lock done");
    bus(8'h00, 1'b1, {17'h0, dom, 8'b00000011});
    `CHK("source", 1'b1, sourceIsPtp)
    base = pktCount;
    src.sendSentence(1'b1, 32'd4000);
    repeat (4) @(posedge clk_sys);
    `CHK("no packets", base, pktCount)
    src.setLocks(1'b0, 1'b0, 1'b1, 32'd100);
    repeat (3) @(posedge clk_sys);
    `CHK("ptp locked", 1'b1, ptpLocked)
    src.setLocks(1'b0, 1'b0, 1'b1, 32'hFFFFFF9B);
    repeat (3) @(posedge clk_sys);
    `CHK("ptp unlocked", 1'b0, ptpLocked)
    src.setLocks(1'b0, 1'b0, 1'b1, 32'hFFFFFF9C);
    base = secCount;
    src.ptpTick(32'd5000);
    repeat (3) @(posedge clk_sys);
    `CHK("full seconds", base + 32'd1, secCount)
    rd("seconds", 8'h14, 32'd5000);
    rd("status", 8'h10, 32'h0000000C);
    $display("ptp done");
    test_done();
  end
endmodule
